//--- logic/rdcout_pkg.sv
// Constants, offsets and field layouts of the resolver output functions
package rdcout_pkg;

  // ***********************************************
  // Clock and measuring periods
  // ***********************************************
  localparam int unsigned CLK_HZ = 10_000_000; // System clock rate
  localparam int unsigned NS_PER_S = 1_000_000_000; // Nanoseconds per second
  localparam int unsigned PER0_NS = 12_800; // Period select 00
  localparam int unsigned PER1_NS = 51_200; // Period select 01
  localparam int unsigned PER2_NS = 102_400; // Period select 10
  localparam int unsigned PER3_NS = 204_800; // Period select 11
  localparam logic [11:0] PER0_CYC = 12'(PER0_NS / (NS_PER_S / CLK_HZ));
  localparam logic [11:0] PER1_CYC = 12'(PER1_NS / (NS_PER_S / CLK_HZ));
  localparam logic [11:0] PER2_CYC = 12'(PER2_NS / (NS_PER_S / CLK_HZ));
  localparam logic [11:0] PER3_CYC = 12'(PER3_NS / (NS_PER_S / CLK_HZ));
  // Left shift that turns an angle delta into 0.07 rpm units
  localparam int unsigned PER0_SHIFT = 10;
  localparam int unsigned PER1_SHIFT = 8;
  localparam int unsigned PER2_SHIFT = 7;
  localparam int unsigned PER3_SHIFT = 6;

  // ***********************************************
  // Register byte offsets
  // ***********************************************
  localparam logic [7:0] EXC_CFG_OFS = 8'h00; // excitation_config_register
  localparam logic [7:0] LOOP_CFG_OFS = 8'h04; // loop_config_register
  localparam logic [7:0] ENC_CTL_OFS = 8'h08; // encoder_control_register
  localparam logic [7:0] CMP_IRQ_OFS = 8'h0c; // compare_irq_register
  localparam logic [7:0] CMP_ANG0_OFS = 8'h10; // compare_angle_0, then +4 each
  localparam logic [7:0] VEL_OFS = 8'h1c; // angular_velocity_value
  localparam logic [7:0] STATUS_OFS = 8'h20; // status

  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int unsigned EXC_EXCITATION_IO_SELECT_BIT = 0; // excitation_io_select
  localparam int unsigned EXC_SENSOR_TYPE_SELECT_BIT = 1; // sensor_type_select
  localparam int unsigned EXC_EXTR_BIT = 2; // Extraction enable
  localparam int unsigned ENC_CINT_BIT = 0; // compare_irq_enable
  localparam int unsigned ENC_HYSTERESIS_BYPASS_BIT = 1; // hysteresis_bypass
  localparam int unsigned ENC_OUTEN_LSB = 2; // A,B,Z,U,V,W enables, 6 bits
  localparam int unsigned ENC_HOLDSEL_BIT = 8; // velocity_hold_select
  localparam int unsigned ENC_PER_LSB = 9; // velocity_period_select, 2 bits
  localparam int unsigned ENC_HOLDTRG_BIT = 11; // velocity_hold_trigger, write 1
  localparam int unsigned CIRQ_LATCH_BIT = 0; // irq_latch_select
  localparam int unsigned CIRQ_FLAG_LSB = 1; // compare_match_flag, 3 bits
  localparam int unsigned CIRQ_CLR_LSB = 4; // compare_match_clear, 3 bits

  // ***********************************************
  // Reset values and resolution
  // ***********************************************
  localparam logic [2:0] EXC_CFG_RST = 3'h2; // VR or brushless resolver
  localparam logic [2:0] MAX_VELOCITY_RESOLUTION_RST = 3'h1; // 12-bit
  localparam logic [10:0] ENC_CTL_RST = 11'h002; // Hysteresis bypassed
  localparam logic [2:0] MAX_VELOCITY_RESOLUTION_12BIT = 3'h1; // Only code allowing hysteresis
  localparam logic [15:0] HYS_BAND = 16'h0018; // 1.5 LSB of a 12-bit angle
  // Commutation sector borders of the 16-bit angle
  localparam logic [15:0] SECT1 = 16'h2aab;
  localparam logic [15:0] SECT2 = 16'h5555;
  localparam logic [15:0] SECT3 = 16'h8000;
  localparam logic [15:0] SECT4 = 16'haaab;
  localparam logic [15:0] SECT5 = 16'hd555;

  // Resolution bit count for each max_velocity_resolution code
  function automatic logic [4:0] rdcout_res_bits(input logic [2:0] max_velocity_resolution);
    case (max_velocity_resolution)
      3'h0: rdcout_res_bits = 5'd10;
      3'h1: rdcout_res_bits = 5'd12;
      3'h2: rdcout_res_bits = 5'd13;
      3'h3: rdcout_res_bits = 5'd14;
      default: rdcout_res_bits = 5'd16;
    endcase
  endfunction

endpackage

//--- logic/rdcout_top.sv
// Resolver output functions: compare interrupts, encoder pulses, velocity
// What this block does
// - DC resolver never uses extraction path
// - Reference follows angle gap when extracting
// - Angle used at selected resolution
// - Three channels raise request on angle match
// - Compared width follows resolution setting
// - Level mode follows live match
// - Latch mode sets flag, request stays
// - Clear blocked only by a live match in latch mode
// - Hysteresis suppresses chatter at 12 bits
// - Lock gates compare, encoder, velocity zero
// - Encoder phases from angle, Z at zero
// - Each encoder output has own enable
// - Bypass bit routes encoder around hysteresis
// - Velocity refreshed at every period end
// - Period select picks four periods
// - Period change accepted any time
// - Velocity signed, 0.07 rpm per LSB
// - Hold freezes velocity on write or pin
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module rdcout_top
  import rdcout_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Tracking loop side, same clock
  input wire logic [15:0] conv_angle_i,
  input wire logic angle_gap_small_i,
  input wire logic angle_error_lock_i,
  // Hold pin, asynchronous
  input wire logic velocity_hold_input_i,
  // Results
  output logic use_extracted_ref_o,
  output logic [2:0] cmp_irq_o,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_z_o,
  output logic enc_u_o,
  output logic enc_v_o,
  output logic enc_w_o
);
  import rdcout_pkg::*;

  // ***********************************************
  // Reset release and pin synchroniser
  // ***********************************************
  logic rst_meta_q; // First reset stage
  logic rst_n; // Synchronised reset
  logic hold_meta_q; // First pin stage, read only by the next stage
  logic hold_sync_q; // Second pin stage
  logic hold_prev_q; // For rising edge

  // Reset goes low at once, leaves on the clock
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Two stages before the edge detector sees the hold pin
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_meta_q <= 1'b0;
      hold_sync_q <= 1'b0;
      hold_prev_q <= 1'b0;
    end
    else
    begin
      hold_meta_q <= velocity_hold_input_i;
      hold_sync_q <= hold_meta_q;
      hold_prev_q <= hold_sync_q;
    end
  end

  // ***********************************************
  // Register storage and bus slave
  // ***********************************************
  logic [2:0] exc_q; // excitation_config_register
  logic [2:0] max_velocity_resolution_q; // max_velocity_resolution
  logic [10:0] enc_q; // encoder_control_register
  logic latch_sel_q; // irq_latch_select
  logic [15:0] cmp_ang_q [3]; // compare_angle_j
  logic aw_have_q; // Write address held
  logic w_have_q; // Write data held
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_en; // Both halves present, answer slot free
  logic wr_hit; // Address is mapped
  logic [2:0] clr_pulse; // compare_match_clear writes
  logic trig_pulse; // velocity_hold_trigger write
  logic [2:0] flag_q; // compare_match_flag
  logic [31:0] vel_read; // Velocity as software sees it
  logic prohibited; // Illegal resolver type code

  assign wr_en = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit = (awaddr_q <= STATUS_OFS) && (awaddr_q[1:0] == 2'h0);
  assign s_axi_awready_o = !aw_have_q;
  assign s_axi_wready_o = !w_have_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // Write channel capture; address and data in either order
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      else if (wr_en)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid_i && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      else if (wr_en)
        w_have_q <= 1'b0;
      // Response one cycle after both halves are held
      if (wr_en)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  // Register writes, byte lanes 0 and 1 only carry fields
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_q <= EXC_CFG_RST;
      max_velocity_resolution_q <= MAX_VELOCITY_RESOLUTION_RST;
      enc_q <= ENC_CTL_RST;
      latch_sel_q <= 1'b0;
      for (int j = 0; j < 3; j++)
        cmp_ang_q[j] <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (awaddr_q == EXC_CFG_OFS)
      begin
        if (wstrb_q[0])
          exc_q <= wdata_q[2:0];
      end
      else if (awaddr_q == LOOP_CFG_OFS)
      begin
        if (wstrb_q[0])
          max_velocity_resolution_q <= wdata_q[2:0];
      end
      else if (awaddr_q == ENC_CTL_OFS)
      begin
        if (wstrb_q[0])
          enc_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1])
          enc_q[10:8] <= wdata_q[10:8];
      end
      else if (awaddr_q == CMP_IRQ_OFS)
      begin
        if (wstrb_q[0])
          latch_sel_q <= wdata_q[CIRQ_LATCH_BIT];
      end
      else
      begin
        // Three compare angle words
        for (int j = 0; j < 3; j++)
        begin
          if (awaddr_q == CMP_ANG0_OFS + 8'(4 * j))
          begin
            if (wstrb_q[0])
              cmp_ang_q[j][7:0] <= wdata_q[7:0];
            if (wstrb_q[1])
              cmp_ang_q[j][15:8] <= wdata_q[15:8];
          end
        end
      end
    end
  end

  // Write-one pulses, not stored
  assign clr_pulse = (wr_en && awaddr_q == CMP_IRQ_OFS && wstrb_q[0]) ?
                     wdata_q[CIRQ_CLR_LSB +: 3] : 3'h0;
  assign trig_pulse = wr_en && awaddr_q == ENC_CTL_OFS && wstrb_q[1] &&
                      wdata_q[ENC_HOLDTRG_BIT];
  assign prohibited = exc_q[EXC_EXCITATION_IO_SELECT_BIT] == exc_q[EXC_SENSOR_TYPE_SELECT_BIT];

  // Read channel; unmapped words answer zero with SLVERR
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end
    else if (s_axi_arvalid_i && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= 2'h0;
      if (s_axi_araddr_i == EXC_CFG_OFS)
        rdata_q <= {29'h0, exc_q};
      else if (s_axi_araddr_i == LOOP_CFG_OFS)
        rdata_q <= {29'h0, max_velocity_resolution_q};
      else if (s_axi_araddr_i == ENC_CTL_OFS)
        rdata_q <= {21'h0, enc_q};
      else if (s_axi_araddr_i == CMP_IRQ_OFS)
        rdata_q <= {28'h0, flag_q, latch_sel_q};
      else if (s_axi_araddr_i == CMP_ANG0_OFS)
        rdata_q <= {16'h0, cmp_ang_q[0]};
      else if (s_axi_araddr_i == CMP_ANG0_OFS + 8'h04)
        rdata_q <= {16'h0, cmp_ang_q[1]};
      else if (s_axi_araddr_i == CMP_ANG0_OFS + 8'h08)
        rdata_q <= {16'h0, cmp_ang_q[2]};
      else if (s_axi_araddr_i == VEL_OFS)
        rdata_q <= vel_read;
      else if (s_axi_araddr_i == STATUS_OFS)
        rdata_q <= {29'h0, prohibited, angle_error_lock_i, use_extracted_ref_o};
      else
      begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= 2'h2;
      end
    end
    else if (s_axi_rready_i)
      rvalid_q <= 1'b0;
  end

  // ***********************************************
  // Excitation reference selection
  // ***********************************************
  // Registered so the loop sees a clean select
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      use_extracted_ref_o <= 1'b0;
    else
      use_extracted_ref_o <= exc_q[EXC_EXTR_BIT] && !exc_q[EXC_EXCITATION_IO_SELECT_BIT] &&
                             exc_q[EXC_SENSOR_TYPE_SELECT_BIT] && angle_gap_small_i;
  end

  // ***********************************************
  // Angle shaping: resolution and hysteresis
  // ***********************************************
  logic [15:0] res_mask; // Bits taking part in compares
  logic [15:0] hys_ang_q; // Angle that moves only past the band
  logic [15:0] hys_diff; // Distance from held angle
  logic hys_on; // Hysteresis in use
  logic [15:0] eff_ang; // Angle seen by compare and encoder
  logic [4:0] res_bits;

  assign res_bits = rdcout_res_bits(max_velocity_resolution_q);
  assign res_mask = 16'hffff << (5'd16 - res_bits);
  assign hys_diff = conv_angle_i - hys_ang_q;
  assign hys_on = !enc_q[ENC_HYSTERESIS_BYPASS_BIT] && (max_velocity_resolution_q == MAX_VELOCITY_RESOLUTION_12BIT);
  assign eff_ang = (hys_on ? hys_ang_q : conv_angle_i) & res_mask;

  // Held angle follows only moves wider than the band, killing jitter
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      hys_ang_q <= 16'h0000;
    else if (!hys_on)
      hys_ang_q <= conv_angle_i;
    else if (hys_diff > HYS_BAND && hys_diff < (16'h0000 - HYS_BAND))
      hys_ang_q <= conv_angle_i;
  end

  // ***********************************************
  // Compare match channels
  // ***********************************************
  logic [2:0] match; // Gated live match per channel

  // Match on the resolution-masked bits, blocked by the lock
  always_comb
  begin
    for (int j = 0; j < 3; j++)
      match[j] = (eff_ang == (cmp_ang_q[j] & res_mask)) && !angle_error_lock_i;
  end

  // Latched flags; a match in the clear cycle keeps the flag
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 3'h0;
    else
    begin
      for (int j = 0; j < 3; j++)
      begin
        if (latch_sel_q && match[j])
          flag_q[j] <= 1'b1;
        else if (clr_pulse[j])
          flag_q[j] <= 1'b0;
      end
    end
  end

  // Request output per channel
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      cmp_irq_o <= 3'h0;
    else if (!enc_q[ENC_CINT_BIT])
      cmp_irq_o <= 3'h0;
    else if (latch_sel_q)
      cmp_irq_o <= flag_q | match;
    else
      cmp_irq_o <= match;
  end

  // ***********************************************
  // Encoder pulse outputs
  // ***********************************************
  logic [15:0] enc_cnt; // Angle counted in resolution steps
  logic [5:0] enc_raw; // A,B,Z,U,V,W before enables

  assign enc_cnt = eff_ang >> (5'd16 - res_bits);
  assign enc_raw[0] = enc_cnt[1];
  assign enc_raw[1] = enc_cnt[1] ^ enc_cnt[0];
  assign enc_raw[2] = eff_ang == 16'h0000;
  assign enc_raw[3] = eff_ang < SECT3;
  assign enc_raw[4] = eff_ang >= SECT2 && eff_ang < SECT5;
  assign enc_raw[5] = eff_ang >= SECT4 || eff_ang < SECT1;

  // Outputs low when disabled or locked
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      {enc_w_o, enc_v_o, enc_u_o, enc_z_o, enc_b_o, enc_a_o} <= 6'h00;
    else
      {enc_w_o, enc_v_o, enc_u_o, enc_z_o, enc_b_o, enc_a_o} <=
        enc_raw & enc_q[ENC_OUTEN_LSB +: 6] & {6{!angle_error_lock_i}};
  end

  // ***********************************************
  // Angular velocity measurement
  // ***********************************************
  logic [1:0] per_sel_q; // Period in force
  logic [11:0] per_cnt_q; // Cycles into the period
  logic [11:0] per_len; // Cycles in the period
  logic [15:0] start_ang_q; // Angle at period start
  logic signed [15:0] delta; // Change over the period
  logic [31:0] vel_q; // Latest periodic result
  logic [31:0] vel_held_q; // Frozen result
  logic [31:0] vel_scaled;
  logic per_end;

  always_comb
  begin
    case (per_sel_q)
      2'h0: per_len = PER0_CYC;
      2'h1: per_len = PER1_CYC;
      2'h2: per_len = PER2_CYC;
      default: per_len = PER3_CYC;
    endcase
  end

  assign per_end = per_cnt_q == per_len - 12'h001;
  assign delta = $signed(conv_angle_i - start_ang_q);

  always_comb
  begin
    case (per_sel_q)
      2'h0: vel_scaled = 32'($signed({{16{delta[15]}}, delta}) <<< PER0_SHIFT);
      2'h1: vel_scaled = 32'($signed({{16{delta[15]}}, delta}) <<< PER1_SHIFT);
      2'h2: vel_scaled = 32'($signed({{16{delta[15]}}, delta}) <<< PER2_SHIFT);
      default: vel_scaled = 32'($signed({{16{delta[15]}}, delta}) <<< PER3_SHIFT);
    endcase
  end

  // Period timer; a new selection restarts it cleanly
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_sel_q <= 2'h0;
      per_cnt_q <= 12'h000;
      start_ang_q <= 16'h0000;
      vel_q <= 32'h0000_0000;
    end
    else if (per_sel_q != enc_q[ENC_PER_LSB +: 2])
    begin
      per_sel_q <= enc_q[ENC_PER_LSB +: 2];
      per_cnt_q <= 12'h000;
      start_ang_q <= conv_angle_i;
    end
    else if (per_end)
    begin
      per_cnt_q <= 12'h000;
      start_ang_q <= conv_angle_i;
      vel_q <= angle_error_lock_i ? 32'h0000_0000 : vel_scaled;
    end
    else
      per_cnt_q <= per_cnt_q + 12'h001;
  end

  // Capture on write or pin edge while holding is enabled
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      vel_held_q <= 32'h0000_0000;
    else if (enc_q[ENC_HOLDSEL_BIT] && (trig_pulse || (hold_sync_q && !hold_prev_q)))
      vel_held_q <= vel_q;
  end

  assign vel_read = angle_error_lock_i ? 32'h0000_0000 :
                    (enc_q[ENC_HOLDSEL_BIT] ? vel_held_q : vel_q);

endmodule

`default_nettype wire

//--- verification/rdcout_properties.sv
// Port relation checker of the resolver output block
`timescale 1ns/10ps
`default_nettype none
module rdcout_properties (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [15:0] conv_angle_i,
  input wire logic angle_gap_small_i,
  input wire logic angle_error_lock_i,
  input wire logic use_extracted_ref_o,
  input wire logic [2:0] cmp_irq_o,
  input wire logic enc_a_o,
  input wire logic enc_b_o,
  input wire logic enc_z_o,
  input wire logic enc_u_o,
  input wire logic enc_v_o,
  input wire logic enc_w_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  a_lock_enc_off:
    assert property (angle_error_lock_i |=> !(enc_a_o || enc_b_o || enc_z_o || enc_u_o
      || enc_v_o || enc_w_o)) else $error("encoder output while locked");
  a_lock_irq_quiet:
    assert property (|(cmp_irq_o & ~$past(cmp_irq_o)) |-> !$past(angle_error_lock_i))
    else $error("compare request rose under lock");
  a_z_near_zero:
    assert property (enc_z_o |-> $past(conv_angle_i[15:6]) == 10'h000
      || $past(conv_angle_i[15:8]) == 8'hff) else $error("index pulse away from zero");
  a_ref_gap:
    assert property (use_extracted_ref_o |-> $past(angle_gap_small_i))
    else $error("extracted reference with large gap");
  a_b_hold:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
      && $stable(s_axi_bresp_o)) else $error("write response dropped early");
  a_r_hold:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
      && $stable(s_axi_rdata_o)) else $error("read data dropped early");
  a_r_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_ar_block:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while answer pending");
  a_b_answer:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");
endmodule
bind rdcout_top rdcout_properties rdcout_properties_inst (.*);
`default_nettype wire

//--- verification/rdcout_sensor_model.sv
// Behavioural resolver and tracking loop feeding the output block
`timescale 1ns/10ps
`default_nettype none
module rdcout_sensor_model (
  input wire logic clk_sys_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  input wire logic [15:0] step_i,
  input wire logic settled_i,
  input wire logic fault_i,
  output logic [15:0] conv_angle_o,
  output logic gap_small_o,
  output logic lock_o
);
  // Angle held, or turning one step per cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (load_i)
      conv_angle_o <= load_val_i;
    else
      conv_angle_o <= conv_angle_o + step_i;
  end
  // gap small only once phase settled
  always_ff @(posedge clk_sys_i)
  begin
    gap_small_o <= settled_i;
    lock_o <= fault_i;
  end
endmodule
`default_nettype wire

//--- verification/rdcout_tb_top.sv
// Testbench of the resolver output block
`timescale 1ns/10ps
`default_nettype none
module rdcout_tb_top;
  import rdcout_pkg::*;
  logic clk_sys_i, rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, velocity_hold_input_i;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rv;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr;
  logic [15:0] conv_angle_i, av, stp;
  logic angle_gap_small_i, angle_error_lock_i, use_extracted_ref_o, ld, settled, fault;
  logic [2:0] cmp_irq_o;
  logic enc_a_o, enc_b_o, enc_z_o, enc_u_o, enc_v_o, enc_w_o;
  logic [11:0] per_cyc [4] = '{PER0_CYC, PER1_CYC, PER2_CYC, PER3_CYC};
  int err_total = 0;
  int n_checks = 0;
  wire logic [7:0] enc = {2'h0, enc_a_o, enc_b_o, enc_z_o, enc_u_o, enc_v_o, enc_w_o};
  rdcout_top rdcout_top_inst (.clk_sys_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .conv_angle_i, .angle_gap_small_i, .angle_error_lock_i,
    .velocity_hold_input_i, .use_extracted_ref_o, .cmp_irq_o, .enc_a_o, .enc_b_o,
    .enc_z_o, .enc_u_o, .enc_v_o, .enc_w_o);
  rdcout_sensor_model rdcout_sensor_model_inst (.clk_sys_i, .load_i(ld), .load_val_i(av),
    .step_i(stp), .settled_i(settled), .fault_i(fault), .conv_angle_o(conv_angle_i),
    .gap_small_o(angle_gap_small_i), .lock_o(angle_error_lock_i));
  // Clock, 100 ns period
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
    end
    while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b1;
    @(posedge clk_sys_i);
    rr = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
    end
    while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b1;
    @(posedge clk_sys_i);
    rv = s_axi_rdata_o;
    rr = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk_reg(rv, exp);
  endtask
  // Hold the angle still, or turn it by a step per cycle
  task automatic ang(input logic [15:0] v, input logic [15:0] s);
    @(posedge clk_sys_i);
    ld <= (s == 16'h0);
    av <= v;
    stp <= s;
    tick(4);
  endtask
  task automatic give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well beyond the longest sequence
  initial
  begin
    tick(60000);
    err_total++;
    give_verdict();
  end
  initial
  begin
    {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, velocity_hold_input_i, settled, fault} = 5'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
    {ld, av, stp} = {1'b1, 32'h0};
    tick(5);
    rstn_i <= 1'b1;
    tick(3);
    rchk(EXC_CFG_OFS, 32'h2);
    rchk(ENC_CTL_OFS, 32'h2);
    rd(8'h40);
    chk_reg({30'h0, rr}, 32'h2);
    wr(8'h40, 32'h0);
    chk_reg({30'h0, rr}, 32'h2);
    wr(ENC_CTL_OFS, 32'hff);
    ang(16'h0, 16'h0);
    chk_pin(enc, 8'h0d);
    ang(16'h9010, 16'h0);
    chk_pin(enc, 8'h12);
    wr(ENC_CTL_OFS, 32'h13);
    ang(16'h0, 16'h0);
    chk_pin(enc, 8'h08);
    wr(ENC_CTL_OFS, 32'hff);
    for (int j = 0; j < 3; j++)
      wr(CMP_ANG0_OFS + 8'(4 * j), 32'h1230 + 32'(j) * 32'h1000);
    for (int j = 0; j < 3; j++)
    begin
      ang(16'h1238 + 16'(j) * 16'h1000, 16'h0);
      chk_pin({5'h0, cmp_irq_o}, 8'h1 << j);
    end
    ang(16'h1240, 16'h0);
    chk_pin({5'h0, cmp_irq_o}, 8'h0);
    wr(LOOP_CFG_OFS, 32'h4);
    ang(16'h1238, 16'h0);
    chk_pin({5'h0, cmp_irq_o}, 8'h0);
    wr(LOOP_CFG_OFS, 32'h1);
    wr(CMP_IRQ_OFS, 32'h1);
    wr(CMP_IRQ_OFS, 32'h11);
    tick(4);
    chk_pin({5'h0, cmp_irq_o}, 8'h1);
    ang(16'h5000, 16'h0);
    chk_pin({5'h0, cmp_irq_o}, 8'h1);
    rchk(CMP_IRQ_OFS, 32'h3);
    wr(CMP_IRQ_OFS, 32'h11);
    tick(4);
    chk_pin({5'h0, cmp_irq_o}, 8'h0);
    rchk(CMP_IRQ_OFS, 32'h1);
    wr(CMP_IRQ_OFS, 32'h0);
    fault <= 1'b1;
    ang(16'h1238, 16'h0);
    chk_pin({5'h0, cmp_irq_o}, 8'h0);
    chk_pin(enc, 8'h0);
    fault <= 1'b0;
    settled <= 1'b1;
    wr(EXC_CFG_OFS, 32'h6);
    tick(4);
    chk_pin({7'h0, use_extracted_ref_o}, 8'h1);
    settled <= 1'b0;
    tick(4);
    chk_pin({7'h0, use_extracted_ref_o}, 8'h0);
    settled <= 1'b1;
    wr(EXC_CFG_OFS, 32'h5);
    tick(4);
    chk_pin({7'h0, use_extracted_ref_o}, 8'h0);
    wr(ENC_CTL_OFS, 32'hfd);
    ang(16'h1230, 16'h0);
    ang(16'h1240, 16'h0);
    chk_pin({5'h0, cmp_irq_o}, 8'h1);
    // Same speed in every period gives the same reading
    ang(16'h0, 16'h1);
    for (int p = 0; p < 4; p++)
    begin
      wr(ENC_CTL_OFS, 32'hff | (32'(p) << 9));
      tick(3 * int'(per_cyc[p]));
      rchk(VEL_OFS, 32'h0002_0000);
    end
    wr(ENC_CTL_OFS, 32'h1ff);
    tick(300);
    wr(ENC_CTL_OFS, 32'h9ff);
    ang(16'h0, 16'hffff);
    tick(300);
    rchk(VEL_OFS, 32'h0002_0000);
    velocity_hold_input_i <= 1'b1;
    tick(4);
    velocity_hold_input_i <= 1'b0;
    tick(6);
    rchk(VEL_OFS, 32'hfffe_0000);
    wr(ENC_CTL_OFS, 32'hff);
    ang(16'h0, 16'h2);
    tick(300);
    rchk(VEL_OFS, 32'h0004_0000);
    fault <= 1'b1;
    tick(4);
    rchk(VEL_OFS, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
